/* File: src/adc_parallel_output_timing.sv */
// digital output side of the sampling converter: pipeline, coding, forwarded clock
`timescale 1ns/1ns
module adc_parallel_output_timing
  import adc_out_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      sample_clock_true,
  input  wire logic                      sample_clock_comp,
  input  wire logic signed [LEVEL_W-1:0] analog_level,
  input  wire logic                      halve_rate_select,
  input  wire logic                      format_select,
  output logic [WORD_W-1:0]              sample_word_bus,
  output logic                           range_flag_true,
  output logic                           range_flag_comp,
  output logic                           fwd_clock_true,
  output logic                           fwd_clock_comp,
  output logic                           clock_in_range,
  output logic                           word_dropped
);

  // pin synchronisers: first stage read only by second
  logic [1:0] ct_sync_q;
  logic [1:0] cc_sync_q;
  logic [1:0] div_sync_q;
  logic [1:0] fmt_sync_q;
  logic       ct_prev_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      ct_sync_q  <= 2'h0;
      cc_sync_q  <= 2'h3;
      div_sync_q <= 2'h0;
      fmt_sync_q <= 2'h0;
      ct_prev_q  <= 1'b0;
    end else begin
      ct_sync_q  <= {ct_sync_q[0], sample_clock_true};
      cc_sync_q  <= {cc_sync_q[0], sample_clock_comp};
      div_sync_q <= {div_sync_q[0], halve_rate_select};
      fmt_sync_q <= {fmt_sync_q[0], format_select};
      ct_prev_q  <= ct_sync_q[1];
    end
  end

  // true rising while complement is low, i.e. complement has fallen
  wire  sample_edge = ct_sync_q[1] && !ct_prev_q && !cc_sync_q[1];
  wire  halve_mode  = !div_sync_q[1];
  wire  offset_bin  = fmt_sync_q[1];

  // rate divider: every other edge kept when halving
  logic keep_tog_q;
  wire  keep_edge = !halve_mode || keep_tog_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      keep_tog_q <= 1'b1;
    end else if (sample_edge) begin
      keep_tog_q <= halve_mode ? ~keep_tog_q : 1'b1;
    end
  end

  // input period measure for duty regeneration
  logic [PERIOD_W-1:0] per_cnt_q;
  logic [PERIOD_W-1:0] period_q;

  always_ff @(posedge mclk) begin
    if (rst) begin
      per_cnt_q <= PERIOD_ONE;
      period_q  <= PERIOD_MAX;
    end else if (sample_edge) begin
      per_cnt_q <= PERIOD_ONE;
      period_q  <= per_cnt_q;
    end else if (per_cnt_q != PERIOD_MAX) begin
      per_cnt_q <= per_cnt_q + PERIOD_ONE;
    end
  end

  // clamp and code one sample
  function automatic sample_s code_sample(input logic signed [LEVEL_W-1:0] lvl,
                                          input logic offset);
    sample_s s;
    logic [WORD_W-1:0] tc;
    s  = '0;
    tc = lvl[WORD_W-1:0];
    if (lvl > POS_FS) begin
      tc           = POS_FS[WORD_W-1:0];
      s.over_range = 1'b1;
    end else if (lvl < NEG_FS) begin
      tc           = NEG_FS[WORD_W-1:0];
      s.over_range = 1'b1;
    end
    // offset binary is two's complement with the sign inverted
    s.word = offset ? (tc ^ SIGN_BIT) : tc;
    return s;
  endfunction : code_sample

  wire sample_s coded = code_sample(analog_level, offset_bin);

  // pipeline advances on every input edge, so latency is in input cycles
  stage_s pipe_q [LATENCY];

  // head stage split out so no stage ever names an index below zero
  genvar gi;
  generate
    for (gi = 0; gi < LATENCY; gi++) begin : g_pipe
      if (gi == 0) begin : g_head
        always_ff @(posedge mclk) begin
          if (rst) begin
            pipe_q[gi] <= '0;
          end else if (sample_edge) begin
            pipe_q[gi] <= '{valid: 1'b1, keep: keep_edge, data: coded};
          end
        end
      end else begin : g_tail
        always_ff @(posedge mclk) begin
          if (rst) begin
            pipe_q[gi] <= '0;
          end else if (sample_edge) begin
            pipe_q[gi] <= pipe_q[gi-1];
          end
        end
      end
    end
  endgenerate

  wire stage_s pipe_out  = pipe_q[LATENCY-1];
  wire         push_word = sample_edge && pipe_out.valid && pipe_out.keep;

  // buffer between pipeline exit and the launch stage
  logic    buf_in_ready;
  logic    buf_out_valid;
  sample_s buf_out_data;
  wire     launch = sample_edge && keep_edge && buf_out_valid;

  word_buffer #(
    .W     ($bits(sample_s)),
    .DEPTH (BUF_DEPTH)
  ) u_buffer (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (push_word),
    .in_ready  (buf_in_ready),
    .in_data   (pipe_out.data),
    .out_valid (buf_out_valid),
    .out_ready (launch),
    .out_data  (buf_out_data)
  );

  // forwarded clock: rises after the fixed delay, high for half the update period
  fwd_state_e          fwd_q;
  fwd_state_e          fwd_d;
  logic [PERIOD_W-1:0] fwd_cnt_q;
  logic [PERIOD_W-1:0] high_len_q;
  wire  [PERIOD_W-1:0] half_len = halve_mode ? period_q : (period_q >> 1);
  wire  [PERIOD_W-1:0] high_len = (half_len == '0) ? PERIOD_ONE : half_len;
  wire                 cnt_done = (fwd_cnt_q == PERIOD_ONE);

  always_comb begin
    fwd_d = fwd_q;
    case (fwd_q)
      FWD_IDLE: if (launch) fwd_d = FWD_WAIT;
      FWD_WAIT: if (cnt_done) fwd_d = FWD_HIGH;
      FWD_HIGH: if (launch) fwd_d = FWD_WAIT;
                else if (cnt_done) fwd_d = FWD_IDLE;
      default:  fwd_d = FWD_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      fwd_q      <= FWD_IDLE;
      fwd_cnt_q  <= PERIOD_ONE;
      high_len_q <= PERIOD_ONE;
    end else begin
      fwd_q <= fwd_d;
      if (launch) begin
        fwd_cnt_q  <= DELAY_CNT;
        high_len_q <= high_len;
      end else if (fwd_q == FWD_WAIT && cnt_done) begin
        fwd_cnt_q <= high_len_q;
      end else if (!cnt_done) begin
        fwd_cnt_q <= fwd_cnt_q - PERIOD_ONE;
      end
    end
  end

  // output registers; data changes at launch, ahead of the forwarded rise
  always_ff @(posedge mclk) begin
    if (rst) begin
      sample_word_bus <= '0;
      range_flag_true <= 1'b0;
      range_flag_comp <= 1'b1;
      fwd_clock_true  <= 1'b0;
      fwd_clock_comp  <= 1'b1;
      clock_in_range  <= 1'b0;
      word_dropped    <= 1'b0;
    end else begin
      if (launch) begin
        sample_word_bus <= buf_out_data.word;
        range_flag_true <= buf_out_data.over_range;
        range_flag_comp <= !buf_out_data.over_range;
      end
      fwd_clock_true <= (fwd_d == FWD_HIGH);
      fwd_clock_comp <= (fwd_d != FWD_HIGH);
      // regeneration only meaningful above the minimum input rate
      clock_in_range <= (period_q <= SLOW_LIMIT);
      word_dropped   <= push_word && !buf_in_ready;
    end
  end

endmodule : adc_parallel_output_timing

/* File: src/adc_out_pkg.sv */
// constants, types and shared layouts for the converter output block
package adc_out_pkg;

  localparam int          WORD_W        = 12;
  localparam int          LEVEL_W       = 14;
  localparam int          LATENCY       = 11;
  localparam int          BUF_DEPTH     = 2;
  localparam int          PERIOD_W      = 8;

  localparam int          MCLK_MHZ      = 125;
  localparam int          FWD_DELAY_PS  = 3870;
  localparam int          FWD_DELAY_RAW = (FWD_DELAY_PS * MCLK_MHZ) / 1000000;
  localparam int          FWD_DELAY_CYC = (FWD_DELAY_RAW < 1) ? 1 : FWD_DELAY_RAW;
  localparam int          MIN_CLK_MHZ   = 20;
  localparam int          MAX_PERIOD_CYC = MCLK_MHZ / MIN_CLK_MHZ;

  localparam logic signed [LEVEL_W-1:0] POS_FS = 14'sh07FF;
  localparam logic signed [LEVEL_W-1:0] NEG_FS = -14'sh0800;
  localparam logic [WORD_W-1:0]         SIGN_BIT = 12'h800;
  localparam logic [PERIOD_W-1:0]       PERIOD_ONE = 8'h01;
  localparam logic [PERIOD_W-1:0]       PERIOD_MAX = 8'hFF;
  localparam logic [PERIOD_W-1:0]       DELAY_CNT  = PERIOD_W'(FWD_DELAY_CYC);
  localparam logic [PERIOD_W-1:0]       SLOW_LIMIT = PERIOD_W'(MAX_PERIOD_CYC);

  typedef struct packed {
    logic              over_range;
    logic [WORD_W-1:0] word;
  } sample_s;

  typedef struct packed {
    logic    valid;
    logic    keep;
    sample_s data;
  } stage_s;

  typedef enum logic [2:0] {
    FWD_IDLE = 3'b001,
    FWD_WAIT = 3'b010,
    FWD_HIGH = 3'b100
  } fwd_state_e;

endpackage : adc_out_pkg

/* File: src/word_buffer.sv */
// two-entry valid/ready buffer for converted words
`timescale 1ns/1ns
module word_buffer
  import adc_out_pkg::*;
#(
  parameter int W     = $bits(sample_s),
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  logic [W-1:0] mem_q [DEPTH];
  logic         wr_ptr_q;
  logic         rd_ptr_q;
  logic [1:0]   count_q;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;

  assign in_ready  = (count_q != 2'(DEPTH));
  assign out_valid = (count_q != 2'h0);
  assign out_data  = mem_q[rd_ptr_q];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= 2'h0;
    end else begin
      if (push) wr_ptr_q <= ~wr_ptr_q;
      if (pop)  rd_ptr_q <= ~rd_ptr_q;
      count_q <= count_q + 2'(push) - 2'(pop);
    end
  end

endmodule : word_buffer

/* File: tb/fwd_receiver.sv */
// receiver model: latches word and flag on the forwarded clock
`timescale 1ns/1ns
module fwd_receiver
  import adc_out_pkg::*;
(
  input  wire logic              fwd_clock_true,
  input  wire logic [WORD_W-1:0] sample_word_bus,
  input  wire logic              range_flag_true,
  output sample_s                captured,
  output time                    cap_time,
  output int                     cap_n
);
  initial cap_n = 0;
  // rising edge only; the falling edge carries no data
  always @(posedge fwd_clock_true) begin
    captured <= {range_flag_true, sample_word_bus};
    cap_time <= $time;
    cap_n    <= cap_n + 1;
  end
endmodule : fwd_receiver

/* File: tb/adc_out_assertions.sv */
// port-level checks for the converter output block
`timescale 1ns/1ns
module adc_out_checker
  import adc_out_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              format_select,
  input wire logic [WORD_W-1:0] sample_word_bus,
  input wire logic              range_flag_true,
  input wire logic              range_flag_comp,
  input wire logic              fwd_clock_true,
  input wire logic              fwd_clock_comp,
  input wire logic              word_dropped
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_flag_pair;
    range_flag_comp == !range_flag_true;
  endproperty
  a_flag_pair: assert property (p_flag_pair) else $error("flag pair mismatch");
  property p_fwd_pair;
    fwd_clock_comp == !fwd_clock_true;
  endproperty
  a_fwd_pair: assert property (p_fwd_pair) else $error("clock pair mismatch");
  property p_stable_rise;
    $rose(fwd_clock_true) |-> $stable(sample_word_bus) && $stable(range_flag_true);
  endproperty
  a_stable_rise: assert property (p_stable_rise) else $error("data moved at rise");
  property p_word_fwd;
    $changed(sample_word_bus) |=> $rose(fwd_clock_true);
  endproperty
  a_word_fwd: assert property (p_word_fwd) else $error("no clock after word");
  property p_flag_fwd;
    $changed(range_flag_true) |=> $rose(fwd_clock_true);
  endproperty
  a_flag_fwd: assert property (p_flag_fwd) else $error("flag off its word");
  property p_clamp_tc;
    range_flag_true && !format_select |-> sample_word_bus inside {12'h7FF, 12'h800};
  endproperty
  a_clamp_tc: assert property (p_clamp_tc) else $error("bad clamp code");
  property p_clamp_bin;
    range_flag_true && format_select |-> sample_word_bus inside {12'hFFF, 12'h000};
  endproperty
  a_clamp_bin: assert property (p_clamp_bin) else $error("bad clamp code");
  property p_no_drop;
    !word_dropped;
  endproperty
  a_no_drop: assert property (p_no_drop) else $error("word lost");
endmodule : adc_out_checker
bind adc_parallel_output_timing adc_out_checker adc_out_checker_i (.mclk, .rst, .format_select,
  .sample_word_bus, .range_flag_true, .range_flag_comp, .fwd_clock_true, .fwd_clock_comp,
  .word_dropped);

/* File: tb/test_adc_parallel_output_timing.sv */
// bench: drives sample clock and levels, scores words caught by the receiver
`timescale 1ns/1ns
module test_adc_parallel_output_timing;
  import adc_out_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, sample_clock_true = 1'b0;
  logic halve_rate_select = 1'b0, format_select = 1'b0;
  logic signed [LEVEL_W-1:0] analog_level = 14'sh0000;
  logic [WORD_W-1:0] sample_word_bus;
  logic range_flag_true, range_flag_comp, fwd_clock_true, fwd_clock_comp;
  logic clock_in_range, word_dropped;
  sample_s got, exp_q[$];
  time got_t, rise_q[$];
  int got_n, fail_count = 0, checks = 0, cyc = 0, period = 6;
  logic signed [LEVEL_W-1:0] lv_tab[10] = '{14'sh0000, 14'sh0001, 14'sh3FFF, 14'sh07FF,
    14'sh3800, 14'sh0800, 14'sh37FF, 14'sh1FFF, 14'sh2000, 14'sh0555};
  always #4 mclk = ~mclk;
  adc_parallel_output_timing adc_parallel_output_timing_i (.mclk, .rst, .sample_clock_true,
    .sample_clock_comp(~sample_clock_true), .analog_level, .halve_rate_select, .format_select,
    .sample_word_bus, .range_flag_true, .range_flag_comp, .fwd_clock_true, .fwd_clock_comp,
    .clock_in_range, .word_dropped);
  fwd_receiver fwd_receiver_i (.fwd_clock_true, .sample_word_bus, .range_flag_true,
    .captured(got), .cap_time(got_t), .cap_n(got_n));
  task automatic cmp_word(string what, sample_s exp, sample_s act);
    checks++;
    if (act !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, act);
    end
  endtask : cmp_word
  task automatic cmp_num(string what, logic [63:0] exp, logic [63:0] act);
    checks++;
    if (act !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, act);
    end
  endtask : cmp_num
  function automatic sample_s conv(logic signed [LEVEL_W-1:0] lv, logic bin);
    sample_s s;
    s.over_range = (lv > POS_FS) || (lv < NEG_FS);
    s.word = (lv > POS_FS) ? 12'h7FF : (lv < NEG_FS) ? 12'h800 : lv[WORD_W-1:0];
    s.word[WORD_W-1] = s.word[WORD_W-1] ^ bin;
    return s;
  endfunction : conv
  // waits 1 ns so the receiver's outputs have all landed
  always @(got_n) begin
    #1;
    if (exp_q.size() == 0) begin
      cmp_num("unexpected word", 64'h0, 64'h1);
    end else begin
      cmp_word("captured word", exp_q.pop_front(), got);
      // pin sync and edge register, pipeline plus buffer stage, then the forward delay
      cmp_num("latency ns", (3 + (LATENCY + 1) * period + FWD_DELAY_CYC) * 8,
              got_t - rise_q.pop_front());
    end
  end
  task automatic send(logic signed [LEVEL_W-1:0] lv, bit keep);
    sample_clock_true <= 1'b1;
    analog_level <= lv;
    if (keep) begin
      exp_q.push_back(conv(lv, format_select));
      rise_q.push_back($time);
    end
    repeat (period / 2) @(posedge mclk);
    sample_clock_true <= 1'b0;
    repeat (period - period / 2) @(posedge mclk);
  endtask : send
  // reset flushes the pipeline, so twelve filler edges drain every real sample
  task automatic run(bit full, bit bin, int per);
    halve_rate_select <= full;
    format_select <= bin;
    period = per;
    rst <= 1'b1;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (lv_tab[i]) send(lv_tab[i], full || (i % 2 == 0));
    cmp_num("clock in range", per <= 6, clock_in_range);
    repeat (12) send(14'sh0000, 1'b0);
    repeat (20) @(posedge mclk);
    cmp_num("words left", 64'h0, exp_q.size());
  endtask : run
  task automatic t_full_twos;
    run(1'b1, 1'b0, 6);
  endtask : t_full_twos
  task automatic t_full_bin;
    run(1'b1, 1'b1, 6);
  endtask : t_full_bin
  task automatic t_halve_slow;
    run(1'b0, 1'b0, 8);
  endtask : t_halve_slow
  task automatic t_halve_bin;
    run(1'b0, 1'b1, 6);
  endtask : t_halve_bin
  task automatic end_sim;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    t_full_twos();
    t_full_bin();
    t_halve_slow();
    t_halve_bin();
    end_sim();
  end
endmodule : test_adc_parallel_output_timing
